// ---- design/wiwc_pkg.sv ----
package wiwc_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PERIPH = 16;
    localparam int NUM_INT = 16;
    localparam int PRIO_W = 3;
    localparam int ADDR_W = 8;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIPH_DIS = 8'h04;
    localparam logic [7:0] ADDR_STOP_IDLE = 8'h08;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONFIG = 8'h14;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RC_IDLE_BIT = 2;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_CAUSE_BIT = 4;
    localparam int RC_SOFT_EN_BIT = 5;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_COUNT_LSB = 8;
    localparam int CF_PSB_LSB = 0;
    localparam int CF_PSA_LSB = 4;
    localparam int CF_EN_BIT = 8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] PERIPH_DIS_RESET = 16'h0000;
    localparam logic [15:0] STOP_IDLE_RESET = 16'h0000;
    localparam logic [15:0] INT_ENABLE_RESET = 16'h0000;
    localparam logic CFG_EN_ERASED = 1'b1;
    localparam logic [1:0] CFG_PSA_ERASED = 2'h3;
    localparam logic [3:0] CFG_PSB_ERASED = 4'hf;

    // ----------------------------------------------------------------
    // Watchdog timing counts and the interrupt priority-off level
    // ----------------------------------------------------------------
    localparam logic [1:0] LOW_POWER_RC_CLOCK_DIV_LAST = 2'h3;
    localparam logic [9:0] PSA_LAST_1 = 10'h000;
    localparam logic [9:0] PSA_LAST_8 = 10'h007;
    localparam logic [9:0] PSA_LAST_64 = 10'h03f;
    localparam logic [9:0] PSA_LAST_512 = 10'h1ff;
    localparam logic [7:0] WDT_COUNT_LAST = 8'hff;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;

    // ----------------------------------------------------------------
    // Power modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_ENTER = 2'b01,
        PM_IDLE = 2'b10,
        PM_SLEEP = 2'b11
    } wiwc_mode_type;

endpackage

// ---- design/wiwc_sync.sv ----
`timescale 1ns/10ps
module wiwc_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Level across the boundary
    input wire logic async_in,
    output logic sync_out
);

    typedef struct packed {
        logic stage1;
        logic stage2;
    } wiwc_sync_type;

    wiwc_sync_type state_ff;
    wiwc_sync_type nxt_state;

    // Two stages; only the second is visible outside
    always_comb begin
        nxt_state = state_ff;
        nxt_state.stage1 = async_in;
        nxt_state.stage2 = state_ff.stage1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stage2;

endmodule

// ---- design/wiwc_wdt_core.sv ----
`timescale 1ns/10ps
module wiwc_wdt_core
    import wiwc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Control
    input wire logic low_power_rc_clock_tick,
    input wire logic wdt_enable,
    input wire logic wdt_clear,
    input wire logic [1:0] cfg_prescale_a,
    input wire logic [3:0] cfg_prescale_b,
    // Result
    output logic [7:0] wdt_count,
    output logic wdt_timeout
);

    typedef struct packed {
        logic [1:0] div;
        logic [9:0] psa;
        logic [3:0] psb;
        logic [7:0] count;
        logic timeout;
    } wiwc_wdt_type;

    wiwc_wdt_type state_ff;
    wiwc_wdt_type nxt_state;

    // Prescaler A terminal count from its field
    function automatic logic [9:0] psa_last(input logic [1:0] sel);
        logic [9:0] last;
        unique case (sel)
            2'h0: last = PSA_LAST_1;
            2'h1: last = PSA_LAST_8;
            2'h2: last = PSA_LAST_64;
            2'h3: last = PSA_LAST_512;
        endcase
        return last;
    endfunction

    // Divider chain; clear beats any pending overflow
    always_comb begin
        nxt_state = state_ff;
        nxt_state.timeout = 1'b0;
        if (wdt_clear || !wdt_enable) begin
            nxt_state.div = '0;
            nxt_state.psa = '0;
            nxt_state.psb = '0;
            nxt_state.count = '0;
        end else if (low_power_rc_clock_tick) begin
            if (state_ff.div == LOW_POWER_RC_CLOCK_DIV_LAST) begin
                nxt_state.div = '0;
                if (state_ff.psa == psa_last(cfg_prescale_a)) begin
                    nxt_state.psa = '0;
                    if (state_ff.psb == cfg_prescale_b) begin
                        nxt_state.psb = '0;
                        if (state_ff.count == WDT_COUNT_LAST) begin
                            nxt_state.count = '0;
                            nxt_state.timeout = 1'b1;
                        end else begin
                            nxt_state.count = state_ff.count + 8'h01;
                        end
                    end else begin
                        nxt_state.psb = state_ff.psb + 4'h1;
                    end
                end else begin
                    nxt_state.psa = state_ff.psa + 10'h001;
                end
            end else begin
                nxt_state.div = state_ff.div + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wdt_count = state_ff.count;
    assign wdt_timeout = state_ff.timeout;

endmodule

// ---- design/wiwc_ctrl.sv ----
`timescale 1ns/10ps
module wiwc_ctrl
    import wiwc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Nonvolatile configuration
    input wire logic cfg_watchdog_enable,
    input wire logic [1:0] cfg_prescale_a,
    input wire logic [3:0] cfg_prescale_b,
    input wire logic clock_fail_monitor_en,
    // Internal RC clock pin
    input wire logic low_power_rc_clock,
    // Processor side
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic clear_watchdog_instr,
    input wire logic [PRIO_W-1:0] cpu_priority,
    input wire logic [NUM_INT-1:0] int_req,
    input wire logic [NUM_INT*PRIO_W-1:0] int_prio,
    input wire logic ext_reset_req,
    // Power and reset control
    output logic cpu_run,
    output logic wake_pulse,
    output logic wake_to_isr,
    output logic sys_reset,
    output logic sys_clk_run,
    output logic low_power_rc_clock_run,
    output logic [NUM_PERIPH-1:0] periph_clk_en,
    output logic [NUM_PERIPH-1:0] periph_access_ok
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        wiwc_mode_type mode;
        logic enter_idle;
        logic cfg_loaded;
        logic cfg_wdt_en;
        logic [1:0] cfg_psa;
        logic [3:0] cfg_psb;
        logic soft_en;
        logic idle_flag;
        logic sleep_flag;
        logic cause_flag;
        logic [NUM_PERIPH-1:0] periph_dis;
        logic [NUM_PERIPH-1:0] stop_idle;
        logic [NUM_INT-1:0] int_en;
        logic [NUM_PERIPH-1:0] periph_clk_en;
        logic [NUM_PERIPH-1:0] periph_access_ok;
        logic cpu_run;
        logic wake_pulse;
        logic wake_to_isr;
        logic sys_reset;
        logic sys_clk_run;
        logic low_power_rc_clock_run;
        logic low_power_rc_clock_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } wiwc_ctrl_type;

    localparam wiwc_ctrl_type CTRL_RESET = '{
        mode: PM_RUN,
        enter_idle: 1'b0,
        cfg_loaded: 1'b0,
        cfg_wdt_en: CFG_EN_ERASED,
        cfg_psa: CFG_PSA_ERASED,
        cfg_psb: CFG_PSB_ERASED,
        soft_en: 1'b0,
        idle_flag: 1'b0,
        sleep_flag: 1'b0,
        cause_flag: 1'b0,
        periph_dis: PERIPH_DIS_RESET,
        stop_idle: STOP_IDLE_RESET,
        int_en: INT_ENABLE_RESET,
        periph_clk_en: '1,
        periph_access_ok: '1,
        cpu_run: 1'b1,
        wake_pulse: 1'b0,
        wake_to_isr: 1'b0,
        sys_reset: 1'b0,
        sys_clk_run: 1'b1,
        low_power_rc_clock_run: 1'b1,
        low_power_rc_clock_prev: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000
    };

    wiwc_ctrl_type state_ff;
    wiwc_ctrl_type nxt_state;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Shared by read and write paths so both agree on the map
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_RESET_CTRL) || (addr == ADDR_PERIPH_DIS) ||
               (addr == ADDR_STOP_IDLE) || (addr == ADDR_INT_ENABLE) ||
               (addr == ADDR_STATUS) || (addr == ADDR_CONFIG);
    endfunction

    // ----------------------------------------------------------------
    // RC clock sampling and watchdog
    // ----------------------------------------------------------------
    logic low_power_rc_clock_sync;
    logic low_power_rc_clock_tick;
    logic wdt_enable;
    logic wdt_clear;
    logic [7:0] wdt_count;
    logic wdt_timeout;

    wiwc_sync u_low_power_rc_clock_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(low_power_rc_clock),
        .sync_out(low_power_rc_clock_sync)
    );

    // Rising edge of the sampled RC clock
    assign low_power_rc_clock_tick = low_power_rc_clock_sync & ~state_ff.low_power_rc_clock_prev;
    assign wdt_enable = state_ff.cfg_wdt_en | state_ff.soft_en;

    wiwc_wdt_core u_wdt (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .low_power_rc_clock_tick(low_power_rc_clock_tick),
        .wdt_enable(wdt_enable),
        .wdt_clear(wdt_clear),
        .cfg_prescale_a(state_ff.cfg_psa),
        .cfg_prescale_b(state_ff.cfg_psb),
        .wdt_count(wdt_count),
        .wdt_timeout(wdt_timeout)
    );

    // ----------------------------------------------------------------
    // Interrupt wake qualification
    // ----------------------------------------------------------------
    logic [NUM_INT-1:0] int_wake;
    logic [NUM_INT-1:0] int_above;

    // Per source: enabled, requesting, and not parked at priority zero
    for (genvar i = 0; i < NUM_INT; i++) begin : g_int
        logic [PRIO_W-1:0] prio;
        assign prio = int_prio[i*PRIO_W +: PRIO_W];
        assign int_wake[i] = int_req[i] & state_ff.int_en[i] & (prio != PRIO_OFF);
        assign int_above[i] = int_wake[i] & (prio > cpu_priority);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic run_mode;
    logic save_mode;
    logic any_reset;
    logic wake_any;
    logic apb_write;
    logic apb_setup;

    assign run_mode = (state_ff.mode == PM_RUN);
    assign save_mode = (state_ff.mode == PM_IDLE) || (state_ff.mode == PM_SLEEP);
    // Time-out while running is a device reset
    assign any_reset = ext_reset_req | (wdt_timeout & ~save_mode);
    assign wake_any = (|int_wake) | wdt_timeout | ext_reset_req;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & state_ff.pready & pwrite;
    assign wdt_clear = any_reset | (run_mode & (power_save_instr | clear_watchdog_instr));

    always_comb begin
        nxt_state = state_ff;
        nxt_state.low_power_rc_clock_prev = low_power_rc_clock_sync;
        nxt_state.wake_pulse = 1'b0;
        nxt_state.wake_to_isr = 1'b0;
        nxt_state.sys_reset = 1'b0;

        // Straps caught once, the cycle after reset release
        if (!state_ff.cfg_loaded) begin
            nxt_state.cfg_loaded = 1'b1;
            nxt_state.cfg_wdt_en = cfg_watchdog_enable;
            nxt_state.cfg_psa = cfg_prescale_a;
            nxt_state.cfg_psb = cfg_prescale_b;
        end

        // Software register writes; hardware sets below take priority
        if (apb_write) begin
            unique case (paddr)
                ADDR_RESET_CTRL: begin
                    nxt_state.idle_flag = pwdata[RC_IDLE_BIT];
                    nxt_state.sleep_flag = pwdata[RC_SLEEP_BIT];
                    nxt_state.cause_flag = pwdata[RC_CAUSE_BIT];
                    nxt_state.soft_en = pwdata[RC_SOFT_EN_BIT];
                end
                ADDR_PERIPH_DIS: nxt_state.periph_dis = pwdata[NUM_PERIPH-1:0];
                ADDR_STOP_IDLE: nxt_state.stop_idle = pwdata[NUM_PERIPH-1:0];
                ADDR_INT_ENABLE: nxt_state.int_en = pwdata[NUM_INT-1:0];
                default: ;
            endcase
        end

        // Power mode sequencing
        unique case (state_ff.mode)
            PM_RUN: begin
                if (power_save_instr && !any_reset) begin
                    nxt_state.mode = PM_ENTER;
                    nxt_state.enter_idle = power_save_idle;
                    nxt_state.cpu_run = 1'b0;
                end
            end
            PM_ENTER: begin
                // Interrupt wake requests wait until entry is complete
                nxt_state.mode = state_ff.enter_idle ? PM_IDLE : PM_SLEEP;
                nxt_state.sys_clk_run = state_ff.enter_idle;
            end
            PM_IDLE, PM_SLEEP: begin
                if (wake_any) begin
                    nxt_state.mode = PM_RUN;
                    nxt_state.cpu_run = 1'b1;
                    nxt_state.sys_clk_run = 1'b1;
                    nxt_state.wake_pulse = 1'b1;
                    // Handler entry only for an interrupt above the processor level
                    nxt_state.wake_to_isr = (|int_above) & ~ext_reset_req;
                    if (state_ff.mode == PM_IDLE) begin
                        nxt_state.idle_flag = 1'b1;
                    end else begin
                        nxt_state.sleep_flag = 1'b1;
                    end
                end
            end
        endcase

        // Every time-out marks the cause, reset or wake alike
        if (wdt_timeout) begin
            nxt_state.cause_flag = 1'b1;
        end

        // Device reset other than power-on
        if (any_reset) begin
            nxt_state.sys_reset = 1'b1;
            nxt_state.soft_en = 1'b0;
            nxt_state.periph_dis = PERIPH_DIS_RESET;
            nxt_state.stop_idle = STOP_IDLE_RESET;
            nxt_state.int_en = INT_ENABLE_RESET;
            if (state_ff.mode == PM_ENTER) begin
                nxt_state.mode = PM_RUN;
                nxt_state.cpu_run = 1'b1;
                nxt_state.sys_clk_run = 1'b1;
            end
        end

        // Module clocks follow the stored bits one cycle later
        for (int p = 0; p < NUM_PERIPH; p++) begin
            nxt_state.periph_clk_en[p] = ~state_ff.periph_dis[p] & state_ff.sys_clk_run &
                ~((state_ff.mode == PM_IDLE) & state_ff.stop_idle[p]);
            nxt_state.periph_access_ok[p] = ~state_ff.periph_dis[p];
        end

        // RC oscillator kept alive for its consumers
        nxt_state.low_power_rc_clock_run = wdt_enable | clock_fail_monitor_en;

        // APB: one wait-free access phase, answer built in setup
        nxt_state.pready = apb_setup;
        nxt_state.pslverr = apb_setup & ~addr_mapped(paddr);
        nxt_state.prdata = 32'h0000_0000;
        if (apb_setup && !pwrite) begin
            unique case (paddr)
                ADDR_RESET_CTRL: begin
                    nxt_state.prdata[RC_IDLE_BIT] = state_ff.idle_flag;
                    nxt_state.prdata[RC_SLEEP_BIT] = state_ff.sleep_flag;
                    nxt_state.prdata[RC_CAUSE_BIT] = state_ff.cause_flag;
                    nxt_state.prdata[RC_SOFT_EN_BIT] = state_ff.soft_en;
                end
                ADDR_PERIPH_DIS: nxt_state.prdata[NUM_PERIPH-1:0] = state_ff.periph_dis;
                ADDR_STOP_IDLE: nxt_state.prdata[NUM_PERIPH-1:0] = state_ff.stop_idle;
                ADDR_INT_ENABLE: nxt_state.prdata[NUM_INT-1:0] = state_ff.int_en;
                ADDR_STATUS: begin
                    nxt_state.prdata[ST_MODE_LSB +: 2] = state_ff.mode;
                    nxt_state.prdata[ST_COUNT_LSB +: 8] = wdt_count;
                end
                ADDR_CONFIG: begin
                    nxt_state.prdata[CF_PSB_LSB +: 4] = state_ff.cfg_psb;
                    nxt_state.prdata[CF_PSA_LSB +: 2] = state_ff.cfg_psa;
                    nxt_state.prdata[CF_EN_BIT] = state_ff.cfg_wdt_en;
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Power-on reset clears every flag, idle flag included
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= CTRL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign cpu_run = state_ff.cpu_run;
    assign wake_pulse = state_ff.wake_pulse;
    assign wake_to_isr = state_ff.wake_to_isr;
    assign sys_reset = state_ff.sys_reset;
    assign sys_clk_run = state_ff.sys_clk_run;
    assign low_power_rc_clock_run = state_ff.low_power_rc_clock_run;
    assign periph_clk_en = state_ff.periph_clk_en;
    assign periph_access_ok = state_ff.periph_access_ok;

endmodule

// ---- test/wiwc_ctrl_asserts.sv ----
`timescale 1ns/10ps
// Watches only the top ports; the bind follows the module
module wiwc_ctrl_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Processor and straps
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic ext_reset_req,
    input wire logic clock_fail_monitor_en,
    // Power and reset control
    input wire logic cpu_run,
    input wire logic wake_pulse,
    input wire logic wake_to_isr,
    input wire logic sys_reset,
    input wire logic sys_clk_run,
    input wire logic low_power_rc_clock_run
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A power-save taken while running with no external reset beside it
    sequence s_save;
        power_save_instr && cpu_run && !ext_reset_req;
    endsequence
    sequence s_idle_save;
        power_save_instr && power_save_idle && cpu_run && !ext_reset_req;
    endsequence
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_save_stops: assert property (s_save |=> !cpu_run [*2])
        else $error("core not held through entry");
    a_idle_clock: assert property (s_idle_save |=> sys_clk_run [*2])
        else $error("system clock stopped in idle");
    a_wake_run: assert property (wake_pulse |-> cpu_run && !$past(cpu_run))
        else $error("wake pulse without clock return");
    a_isr_wake: assert property (wake_to_isr |-> wake_pulse)
        else $error("handler entry without wake");
    a_reset_once: assert property (sys_reset |=> !sys_reset)
        else $error("reset pulse too long");
    a_rc_kept: assert property (clock_fail_monitor_en [*3] |-> low_power_rc_clock_run)
        else $error("rc clock stopped with monitor on");
    a_ext_wake: assert property (ext_reset_req && !cpu_run |-> ##[1:3] (cpu_run && wake_pulse))
        else $error("reset did not wake core");
endmodule

bind wiwc_ctrl wiwc_ctrl_chk i_chk (.core_clk, .rst_b, .psel, .penable, .pready,
    .power_save_instr, .power_save_idle, .ext_reset_req, .clock_fail_monitor_en, .cpu_run,
    .wake_pulse, .wake_to_isr, .sys_reset, .sys_clk_run, .low_power_rc_clock_run);

// ---- test/wiwc_cpu_model.sv ----
`timescale 1ns/10ps
// Processor core stand-in: turns bench requests into instruction pulses
module wiwc_cpu_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Requests and core state
    input wire logic go_save,
    input wire logic go_idle,
    input wire logic go_clr,
    input wire logic cpu_run,
    // Instruction pulses
    output logic power_save_instr,
    output logic power_save_idle,
    output logic clear_watchdog_instr
);
    // A stopped core issues nothing, so no pulse lands mid-sleep
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_save_instr <= 1'b0;
            clear_watchdog_instr <= 1'b0;
        end else begin
            power_save_instr <= go_save && cpu_run && !power_save_instr;
            clear_watchdog_instr <= go_clr && cpu_run;
        end
    end
    assign power_save_idle = go_idle;
endmodule

// ---- test/watchdog_idle_wake_ctrl_tb.sv ----
`timescale 1ns/10ps
module watchdog_idle_wake_ctrl_tb
    import wiwc_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic e;
    } wiwc_row_type;
    wiwc_row_type rows [6] = '{'{ADDR_RESET_CTRL, 32'h0, 1'b0}, '{ADDR_PERIPH_DIS, 32'h0, 1'b0},
        '{ADDR_STOP_IDLE, 32'h0, 1'b0}, '{ADDR_INT_ENABLE, 32'h0, 1'b0},
        '{ADDR_CONFIG, 32'h100, 1'b0}, '{8'h18, 32'h0, 1'b1}};
    logic core_clk = 1'b0, rst_b = 1'b0, rc_clk = 1'b0, ext_reset_req = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go_save = 1'b0, go_idle = 1'b0;
    logic go_clr = 1'b0, err, ps_instr, ps_idle, clr_instr;
    logic pready, pslverr, cpu_run, wake_pulse, wake_to_isr, sys_reset, sys_clk_run, low_power_rc_clock_run;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [2:0] cpu_priority = 3'h1;
    logic [15:0] int_req = 16'h0000, periph_clk_en, periph_access_ok;
    logic [47:0] int_prio = 48'h18; // Source 0 at level 0, source 1 at level 3
    int fail_count = 0, n_compared = 0, n_rst = 0, n;

    wiwc_ctrl i_dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cfg_watchdog_enable(1'b1), .cfg_prescale_a(2'h0),
        .cfg_prescale_b(4'h0), .clock_fail_monitor_en(1'b1), .low_power_rc_clock(rc_clk),
        .power_save_instr(ps_instr), .power_save_idle(ps_idle), .clear_watchdog_instr(clr_instr),
        .cpu_priority, .int_req, .int_prio, .ext_reset_req, .cpu_run, .wake_pulse, .wake_to_isr,
        .sys_reset, .sys_clk_run, .low_power_rc_clock_run, .periph_clk_en, .periph_access_ok);
    wiwc_cpu_model i_cpu (.core_clk, .rst_b, .go_save, .go_idle, .go_clr, .cpu_run,
        .power_save_instr(ps_instr), .power_save_idle(ps_idle), .clear_watchdog_instr(clr_instr));

    // ------------------------------------------------
    // Clocks, reset counter, helpers
    // ------------------------------------------------
    initial forever #20 core_clk = ~core_clk;
    // Shortened RC clock, 5 core cycles, so a time-out is 5120 cycles
    initial begin
        #7;
        forever #100 rc_clk = ~rc_clk;
    end
    always @(negedge core_clk) n_rst += int'(sys_reset === 1'b1);

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang(input string m);
        fail_count++;
        $display("BAD t=%0t %s", $time, m);
        finish_test();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Zero-wait slave expected, but the wait is bounded anyway
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge core_clk);
            k++;
        end
        if (pready !== 1'b1) hang("no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic save(input logic idle);
        @(posedge core_clk);
        go_idle <= idle;
        go_save <= 1'b1;
        @(posedge core_clk);
        go_save <= 1'b0;
        #1;
    endtask
    task automatic wait_wake(input int lim);
        n = 0;
        while (wake_pulse !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == lim) hang("no wake");
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        apb(1'b1, ADDR_CONFIG, 32'hffff_ffff);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            check(rd, rows[i].d);
            check(32'(err), 32'(rows[i].e));
        end
        $display("done: register defaults");
        for (int k = 1; k >= 0; k--) begin
            apb(1'b1, ADDR_PERIPH_DIS, 32'(k));
            #1;
            check(32'(periph_clk_en[0]), 32'(k));
            @(posedge core_clk);
            #1;
            check(32'({periph_access_ok[0], periph_clk_en[0]}), 32'(3 - 3 * k));
        end
        $display("done: module disable");
        apb(1'b1, ADDR_STOP_IDLE, 32'h2);
        apb(1'b1, ADDR_INT_ENABLE, 32'h3);
        save(1'b1);
        repeat (5) @(posedge core_clk);
        int_req <= 16'h0001;
        repeat (8) @(posedge core_clk);
        #1;
        check(32'({cpu_run, sys_clk_run, periph_clk_en[1:0]}), 32'h5);
        @(posedge core_clk);
        int_req <= 16'h0003;
        #1;
        wait_wake(3);
        check(32'(wake_to_isr), 32'h1);
        apb(1'b0, ADDR_RESET_CTRL, 32'h0);
        check(rd, 32'h4);
        apb(1'b1, ADDR_RESET_CTRL, 32'h0);
        int_req <= 16'h0002;
        cpu_priority <= 3'h3;
        save(1'b1);
        wait_wake(6);
        check(32'(wake_to_isr), 32'h0);
        apb(1'b1, ADDR_RESET_CTRL, 32'h0);
        int_req <= 16'h0000;
        $display("done: interrupt wake");
        for (int k = 1; k >= 0; k--) begin
            save(k[0]);
            wait_wake(5200);
            check(32'(n > 5100), 32'h1);
            apb(1'b0, ADDR_RESET_CTRL, 32'h0);
            check(rd, k ? 32'h14 : 32'h18);
            apb(1'b1, ADDR_RESET_CTRL, 32'h0);
        end
        $display("done: watchdog wake");
        repeat (4000) @(posedge core_clk);
        go_clr <= 1'b1;
        @(posedge core_clk);
        go_clr <= 1'b0;
        repeat (5000) @(posedge core_clk);
        check(32'(n_rst), 32'h0);
        repeat (400) @(posedge core_clk);
        check(32'(n_rst), 32'h1);
        apb(1'b0, ADDR_RESET_CTRL, 32'h0);
        check(rd, 32'h10);
        apb(1'b1, ADDR_RESET_CTRL, 32'h20);
        save(1'b1);
        repeat (4) @(posedge core_clk);
        ext_reset_req <= 1'b1;
        @(posedge core_clk);
        ext_reset_req <= 1'b0;
        #1;
        wait_wake(4);
        apb(1'b0, ADDR_RESET_CTRL, 32'h0);
        check(rd, 32'h4);
        $display("done: reset wake");
        finish_test();
    end
endmodule
